// [common/aec_pkg.sv]
// Constants, types and helper functions for the audio enhancement chain control block
package aec_pkg;
   localparam int SW = 16;
   localparam int QSHIFT = 12;
   localparam int AW = 8;
   localparam int BANDS = 5;
   // Register offsets
   localparam logic [7:0] ADDR_DYN_CTRL1 = 8'h1D;
   localparam logic [7:0] ADDR_DYN_CTRL2 = 8'h1E;
   localparam logic [7:0] ADDR_DYN_CTRL4 = 8'h20;
   localparam logic [7:0] ADDR_DYN_GAIN = 8'h24;
   localparam logic [7:0] ADDR_MODE = 8'h40;
   localparam logic [7:0] ADDR_LHP_CFG = 8'h41;
   localparam logic [7:0] ADDR_LHP_COEF = 8'h42;
   localparam logic [7:0] ADDR_NOTCH_CFG = 8'h47;
   localparam logic [7:0] ADDR_NOTCH_K1 = 8'h48;
   localparam logic [7:0] ADDR_NOTCH_K2 = 8'h49;
   localparam logic [7:0] ADDR_NOTCH_DEPTH = 8'h4A;
   localparam logic [7:0] ADDR_DF_CFG = 8'h5C;
   localparam logic [7:0] ADDR_DF_C1 = 8'h5D;
   localparam logic [7:0] ADDR_DF_C2 = 8'h5E;
   localparam logic [7:0] ADDR_DF_C3 = 8'h5F;
   localparam logic [7:0] ADDR_AEQ_CFG = 8'h64;
   localparam logic [7:0] ADDR_AEQ_G0 = 8'h65;
   localparam logic [7:0] ADDR_AEQ_G1 = 8'h66;
   localparam logic [7:0] ADDR_AEQ_DLY = 8'h67;
   localparam logic [7:0] ADDR_BEQ_CFG = 8'h85;
   localparam logic [7:0] ADDR_BEQ_K0 = 8'h86;
   localparam logic [7:0] ADDR_BEQ_G0 = 8'h8A;
   // Field positions
   localparam int BIT_ENABLE = 0;
   localparam int BIT_LHP_HIGH = 1;
   localparam int BIT_DYN_ENABLE = 7;
   localparam int BIT_DYN_GATE = 8;
   localparam int BIT_ANTICLIP = 0;
   localparam int BIT_QUICK_REL = 1;
   localparam int KNEE_LSB = 2;
   localparam int KNEE2_LSB = 8;
   localparam logic [3:0] MODE_RECORD = 4'h0;
   localparam logic [3:0] MODE_PLAYBACK = 4'h1;
   localparam logic [15:0] REG_RESET = 16'h0000;
   // Dynamics constants (Q12 gain)
   localparam logic signed [15:0] GAIN_UNITY = 16'sh1000;
   localparam logic signed [15:0] GAIN_MAX = 16'sh2000;
   localparam logic signed [15:0] GAIN_MIN = 16'sh0040;
   localparam logic signed [15:0] STEP_ATTACK = 16'sh0010;
   localparam logic signed [15:0] STEP_RELEASE = 16'sh0001;
   localparam logic signed [15:0] STEP_QUICK = 16'sh0020;
   localparam logic [15:0] CLIP_LEVEL = 16'h7000;
   localparam logic [15:0] FULL_SCALE = 16'h7FFF;
   localparam int KNEE_DIV = 3;
   localparam int KNEE2_DIV = 2;
   localparam int KNEE2_BASE = 6;
   localparam int GATE_SHIFT = 4;
   localparam logic signed [4:0] BAND_DB_MAX = 5'sd12;

   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_LHP = 8'h02,
      ST_NOTCH = 8'h04,
      ST_DF = 8'h08,
      ST_AEQ = 8'h10,
      ST_BEQ = 8'h20,
      ST_DYN = 8'h40,
      ST_OUT = 8'h80
   } aec_state_t;

   // Saturate a wide value to one sample
   function automatic logic signed [15:0] aec_sat(input logic signed [31:0] v);
      if (v > 32'sh00007FFF) begin
         return 16'sh7FFF;
      end else if (v < -32'sh00008000) begin
         return -16'sh8000;
      end
      return v[15:0];
   endfunction

   // Q12 multiply with saturation
   function automatic logic signed [15:0] aec_mul(input logic signed [15:0] a,
                                                  input logic signed [15:0] b);
      logic signed [31:0] p;
      p = a * b;
      return aec_sat(p >>> QSHIFT);
   endfunction

   // Saturating add and subtract
   function automatic logic signed [15:0] aec_add(input logic signed [15:0] a,
                                                  input logic signed [15:0] b);
      return aec_sat(32'(a) + 32'(b));
   endfunction

   function automatic logic signed [15:0] aec_sub(input logic signed [15:0] a,
                                                  input logic signed [15:0] b);
      return aec_sat(32'(a) - 32'(b));
   endfunction

   // Band gain code in dB to Q12 linear gain, clamped to +/-12 dB
   function automatic logic signed [15:0] aec_band_gain(input logic signed [4:0] code);
      logic signed [4:0] c;
      c = code;
      if (c > BAND_DB_MAX) c = BAND_DB_MAX;
      if (c < -BAND_DB_MAX) c = -BAND_DB_MAX;
      case (c)
         5'sd1: return 16'sh11F4;
         5'sd2: return 16'sh1425;
         5'sd3: return 16'sh169A;
         5'sd4: return 16'sh195C;
         5'sd5: return 16'sh1C74;
         5'sd6: return 16'sh1FED;
         5'sd7: return 16'sh23D2;
         5'sd8: return 16'sh2831;
         5'sd9: return 16'sh2D18;
         5'sd10: return 16'sh3299;
         5'sd11: return 16'sh38C5;
         5'sd12: return 16'sh3FB2;
         -5'sd1: return 16'sh0E43;
         -5'sd2: return 16'sh0CB6;
         -5'sd3: return 16'sh0B54;
         -5'sd4: return 16'sh0A18;
         -5'sd5: return 16'sh08FF;
         -5'sd6: return 16'sh0805;
         -5'sd7: return 16'sh0725;
         -5'sd8: return 16'sh065E;
         -5'sd9: return 16'sh05AD;
         -5'sd10: return 16'sh050F;
         -5'sd11: return 16'sh0482;
         -5'sd12: return 16'sh0405;
         default: return GAIN_UNITY;
      endcase
   endfunction

   // Magnitude of a sample
   function automatic logic [15:0] aec_abs(input logic signed [15:0] v);
      if (v == -16'sh8000) return FULL_SCALE;
      return v[15] ? 16'(-v) : v;
   endfunction
endpackage

// [rtl/aec_chain.sv]
// Audio enhancement chain: registers, path placement and the six stages
module aec_chain import aec_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [AW-1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   // Record path in (from converter)
   input wire logic rec_in_valid,
   output logic rec_in_ready,
   input wire logic signed [SW-1:0] rec_in_data,
   // Playback path in (from audio interface)
   input wire logic play_in_valid,
   output logic play_in_ready,
   input wire logic signed [SW-1:0] play_in_data,
   // Record path out
   output logic rec_out_valid,
   input wire logic rec_out_ready,
   output logic signed [SW-1:0] rec_out_data,
   // Playback path out
   output logic play_out_valid,
   input wire logic play_out_ready,
   output logic signed [SW-1:0] play_out_data
);
   logic [15:0] regs [2**AW];
   aec_state_t state;
   logic signed [15:0] acc;
   logic signed [15:0] drc_gain;
   logic peak_seen;
   logic signed [15:0] lhp_lp, n_lp1, n_lp2, df_x1, df_y1;
   logic signed [15:0] aeq_dly [4];
   logic signed [15:0] beq_lp [BANDS-1];
   logic signed [15:0] beq_band [BANDS];
   logic signed [15:0] next_lhp_lp, next_n_lp1, next_n_lp2, next_acc;
   logic signed [15:0] next_gain;
   logic [15:0] mag, thr, gate_thr;
   logic play_mode, eng_ready, enh_in_valid, enh_buf_ready;
   logic signed [SW-1:0] enh_in_data, dir_in_data, enh_out_data, dir_out_data;
   logic dir_in_valid, dir_in_ready, enh_out_valid, enh_out_ready;
   logic dir_out_valid, dir_out_ready;

   // Selected bit b of a configuration register
   function automatic logic cfg_on(input logic [15:0] r, input int b);
      return r[b];
   endfunction

   // Register writes; all fields reset to their disabled defaults
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 2**AW; i++) regs[i] <= REG_RESET;
      end else if (reg_wr && reg_addr != ADDR_DYN_GAIN) begin
         regs[reg_addr] <= reg_wdata;
      end
   end

   // Register reads; gain status reflects live dynamics state
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= (reg_addr == ADDR_DYN_GAIN) ? drc_gain : regs[reg_addr];
      end
   end

   // Path placement: reserved modes behave as record
   assign play_mode = (regs[ADDR_MODE][3:0] == MODE_PLAYBACK);
   assign enh_in_valid = play_mode ? play_in_valid : rec_in_valid;
   assign enh_in_data = play_mode ? play_in_data : rec_in_data;
   assign dir_in_valid = play_mode ? rec_in_valid : play_in_valid;
   assign dir_in_data = play_mode ? rec_in_data : play_in_data;
   assign rec_in_ready = play_mode ? dir_in_ready : eng_ready;
   assign play_in_ready = play_mode ? eng_ready : dir_in_ready;
   assign rec_out_valid = play_mode ? dir_out_valid : enh_out_valid;
   assign rec_out_data = play_mode ? dir_out_data : enh_out_data;
   assign play_out_valid = play_mode ? enh_out_valid : dir_out_valid;
   assign play_out_data = play_mode ? enh_out_data : dir_out_data;
   assign enh_out_ready = play_mode ? play_out_ready : rec_out_ready;
   assign dir_out_ready = play_mode ? rec_out_ready : play_out_ready;
   assign eng_ready = (state == ST_IDLE);

   // Sequencer: one cycle per stage, in chain order
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: if (enh_in_valid) state <= ST_LHP;
            ST_LHP: state <= ST_NOTCH;
            ST_NOTCH: state <= ST_DF;
            ST_DF: state <= ST_AEQ;
            ST_AEQ: state <= ST_BEQ;
            ST_BEQ: state <= ST_DYN;
            ST_DYN: state <= ST_OUT;
            ST_OUT: if (enh_buf_ready) state <= ST_IDLE;
         endcase
      end
   end

   // Five-band split: four low-pass sections, bands are their differences
   assign beq_band[0] = beq_lp[0];
   assign beq_band[BANDS-1] = aec_sub(acc, beq_lp[BANDS-2]);
   generate
      for (genvar b = 1; b < BANDS-1; b++) begin : g_mid
         assign beq_band[b] = aec_sub(beq_lp[b], beq_lp[b-1]);
      end
   endgenerate

   // Dynamics thresholds from knee codes
   assign mag = aec_abs(acc);
   assign thr = FULL_SCALE >> (regs[ADDR_DYN_CTRL4][KNEE_LSB +: 6] >> KNEE_DIV);
   assign gate_thr = FULL_SCALE >> (KNEE2_BASE
                     + (regs[ADDR_DYN_CTRL4][KNEE2_LSB +: 5] >> KNEE2_DIV));

   // Stage arithmetic for the current state
   always_comb begin
      logic signed [31:0] sum;
      logic signed [15:0] s;
      sum = '0;
      s = '0;
      next_lhp_lp = aec_add(lhp_lp, aec_mul(regs[ADDR_LHP_COEF], aec_sub(acc, lhp_lp)));
      next_n_lp1 = aec_add(n_lp1, aec_mul(regs[ADDR_NOTCH_K1], aec_sub(acc, n_lp1)));
      next_n_lp2 = aec_add(n_lp2, aec_mul(regs[ADDR_NOTCH_K2], aec_sub(acc, n_lp2)));
      next_gain = drc_gain;
      next_acc = acc;
      unique case (state)
         ST_IDLE: next_acc = enh_in_data;
         ST_LHP: if (cfg_on(regs[ADDR_LHP_CFG], BIT_ENABLE)) begin
            next_acc = cfg_on(regs[ADDR_LHP_CFG], BIT_LHP_HIGH) ?
                       aec_sub(acc, next_lhp_lp) : next_lhp_lp;
         end
         ST_NOTCH: if (cfg_on(regs[ADDR_NOTCH_CFG], BIT_ENABLE)) begin
            next_acc = aec_sub(acc, aec_mul(regs[ADDR_NOTCH_DEPTH],
                                            aec_sub(next_n_lp1, next_n_lp2)));
         end
         ST_DF: if (cfg_on(regs[ADDR_DF_CFG], BIT_ENABLE)) begin
            sum = 32'(aec_mul(regs[ADDR_DF_C1], acc)) + 32'(aec_mul(regs[ADDR_DF_C2], df_x1))
                  + 32'(aec_mul(regs[ADDR_DF_C3], df_y1));
            next_acc = aec_sat(sum);
         end
         ST_AEQ: if (cfg_on(regs[ADDR_AEQ_CFG], BIT_ENABLE)) begin
            sum = 32'(aec_mul(regs[ADDR_AEQ_G0], acc))
                  + 32'(aec_mul(regs[ADDR_AEQ_G1], aeq_dly[regs[ADDR_AEQ_DLY][1:0]]));
            next_acc = aec_sat(sum);
         end
         ST_BEQ: if (cfg_on(regs[ADDR_BEQ_CFG], BIT_ENABLE)) begin
            for (int b = 0; b < BANDS; b++) begin
               sum = sum + 32'(aec_mul(aec_band_gain(regs[ADDR_BEQ_G0 + 8'(b)][4:0]),
                                       beq_band[b]));
            end
            next_acc = aec_sat(sum);
         end
         ST_DYN: if (cfg_on(regs[ADDR_DYN_CTRL1], BIT_DYN_ENABLE)) begin
            if (cfg_on(regs[ADDR_DYN_CTRL2], BIT_ANTICLIP) && mag >= CLIP_LEVEL) begin
               next_gain = drc_gain >>> 1;
            end else if (aec_abs(aec_mul(acc, drc_gain)) > thr) begin
               next_gain = drc_gain - STEP_ATTACK;
            end else if (peak_seen && cfg_on(regs[ADDR_DYN_CTRL2], BIT_QUICK_REL)) begin
               next_gain = drc_gain + STEP_QUICK;
            end else begin
               next_gain = drc_gain + STEP_RELEASE;
            end
            if (next_gain > GAIN_MAX) next_gain = GAIN_MAX;
            if (next_gain < GAIN_MIN) next_gain = GAIN_MIN;
            s = aec_mul(acc, next_gain);
            if (cfg_on(regs[ADDR_DYN_CTRL1], BIT_DYN_GATE) && mag < gate_thr) begin
               s = s >>> GATE_SHIFT;
            end
            next_acc = s;
         end
         ST_OUT: next_acc = acc;
      endcase
   end

   // Working sample
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) acc <= '0;
      else acc <= next_acc;
   end

   // Stage-one filter memories, advanced only while enabled
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         lhp_lp <= '0;
         n_lp1 <= '0;
         n_lp2 <= '0;
         df_x1 <= '0;
         df_y1 <= '0;
      end else begin
         if (state == ST_LHP && cfg_on(regs[ADDR_LHP_CFG], BIT_ENABLE)) lhp_lp <= next_lhp_lp;
         if (state == ST_NOTCH && cfg_on(regs[ADDR_NOTCH_CFG], BIT_ENABLE)) begin
            n_lp1 <= next_n_lp1;
            n_lp2 <= next_n_lp2;
         end
         if (state == ST_DF && cfg_on(regs[ADDR_DF_CFG], BIT_ENABLE)) begin
            df_x1 <= acc;
            df_y1 <= next_acc;
         end
      end
   end

   // Stage-two memories: delay line and band splitters
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 4; i++) aeq_dly[i] <= '0;
         for (int i = 0; i < BANDS-1; i++) beq_lp[i] <= '0;
      end else begin
         if (state == ST_AEQ && cfg_on(regs[ADDR_AEQ_CFG], BIT_ENABLE)) begin
            aeq_dly[0] <= acc;
            for (int i = 1; i < 4; i++) aeq_dly[i] <= aeq_dly[i-1];
         end
         if (state == ST_BEQ && cfg_on(regs[ADDR_BEQ_CFG], BIT_ENABLE)) begin
            for (int i = 0; i < BANDS-1; i++) begin
               beq_lp[i] <= aec_add(beq_lp[i],
                  aec_mul(regs[ADDR_BEQ_K0 + 8'(i)], aec_sub(acc, beq_lp[i])));
            end
         end
      end
   end

   // Dynamics gain and transient memory
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         drc_gain <= GAIN_UNITY;
         peak_seen <= 1'b0;
      end else if (state == ST_DYN && cfg_on(regs[ADDR_DYN_CTRL1], BIT_DYN_ENABLE)) begin
         drc_gain <= next_gain;
         peak_seen <= (mag >= CLIP_LEVEL) || (peak_seen && next_gain < GAIN_UNITY);
      end
   end

   // Output buffers for both paths
   aec_skid_buffer #(.WIDTH(SW), .DEPTH(2)) u_enh_buf (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .in_valid(state == ST_OUT),
      .in_ready(enh_buf_ready),
      .in_data(acc),
      .out_valid(enh_out_valid),
      .out_ready(enh_out_ready),
      .out_data(enh_out_data)
   );

   aec_skid_buffer #(.WIDTH(SW), .DEPTH(2)) u_dir_buf (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .in_valid(dir_in_valid),
      .in_ready(dir_in_ready),
      .in_data(dir_in_data),
      .out_valid(dir_out_valid),
      .out_ready(dir_out_ready),
      .out_data(dir_out_data)
   );
endmodule

// [rtl/aec_skid_buffer.sv]
// Two-entry sample buffer with valid/ready on both sides
module aec_skid_buffer import aec_pkg::*; #(
   parameter int WIDTH = SW,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;
   logic push;
   logic pop;

   // Handshakes
   assign in_ready = (count != (PW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   // Storage
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
      end else if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         if (pop) rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         count <= count + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule

// [tb/aec_audio_sink.sv]
// Far-side model: converter and interface sinks of both sample paths
module aec_audio_sink (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Stall request from the bench
   input wire logic stall,
   // Record path
   input wire logic rec_out_valid,
   output logic rec_out_ready,
   input wire logic signed [15:0] rec_out_data,
   // Playback path
   input wire logic play_out_valid,
   output logic play_out_ready,
   input wire logic signed [15:0] play_out_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic signed [15:0] rec_q [$];
   logic signed [15:0] play_q [$];
   // Sinks accept whenever not stalled
   assign rec_out_ready = rst_b && !stall;
   assign play_out_ready = rst_b && !stall;
   // Keep accepted words in arrival order
   always @(posedge core_clk) begin
      if (rec_out_valid && rec_out_ready) begin
         rec_q.push_back(rec_out_data);
      end
      if (play_out_valid && play_out_ready) begin
         play_q.push_back(play_out_data);
      end
   end
endmodule

// [tb/aec_chain_assertions.sv]
// Port timing checker for the enhancement chain
module aec_chain_assertions import aec_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [AW-1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   // Sample inputs
   input wire logic rec_in_valid,
   input wire logic rec_in_ready,
   input wire logic signed [SW-1:0] rec_in_data,
   input wire logic play_in_valid,
   input wire logic play_in_ready,
   input wire logic signed [SW-1:0] play_in_data,
   // Sample outputs
   input wire logic rec_out_valid,
   input wire logic rec_out_ready,
   input wire logic signed [SW-1:0] rec_out_data,
   input wire logic play_out_valid,
   input wire logic play_out_ready,
   input wire logic signed [SW-1:0] play_out_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] mode_q;
   logic rec_enh;
   logic rec_take;
   logic play_take;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Shadow of the placement mode field
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= 4'h0;
      end else if (reg_wr && reg_addr == ADDR_MODE) begin
         mode_q <= reg_wdata[3:0];
      end
   end
   // Path selection and accepted samples
   assign rec_enh = (mode_q != MODE_PLAYBACK);
   assign rec_take = rec_in_valid && rec_in_ready;
   assign play_take = play_in_valid && play_in_ready;

   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_mode_readback: assert property (reg_rd && !reg_wr && reg_addr == ADDR_MODE
      |=> reg_rdata[3:0] == $past(mode_q)) else $error("mode read-back wrong");
   a_rec_out_hold: assert property (rec_out_valid && !rec_out_ready
      |=> rec_out_valid && $stable(rec_out_data)) else $error("record output dropped");
   a_play_out_hold: assert property (play_out_valid && !play_out_ready
      |=> play_out_valid && $stable(play_out_data)) else $error("playback output dropped");
   a_rec_enh_gap: assert property (rec_enh && rec_take |=> !rec_in_ready [*7])
      else $error("record engine accepted too early");
   a_rec_enh_lat: assert property (rec_enh && rec_take && !rec_out_valid
      |=> !rec_out_valid [*7] ##1 rec_out_valid) else $error("record latency wrong");
   a_play_enh_lat: assert property (!rec_enh && play_take && !play_out_valid
      |=> !play_out_valid [*7] ##1 play_out_valid) else $error("playback latency wrong");
   a_play_direct: assert property (rec_enh && play_take && !play_out_valid
      |=> play_out_valid && play_out_data == $past(play_in_data))
      else $error("direct playback path wrong");
   a_rec_direct: assert property (!rec_enh && rec_take && !rec_out_valid
      |=> rec_out_valid && rec_out_data == $past(rec_in_data))
      else $error("direct record path wrong");
   // Main scenarios reached
   c_rec_enh: cover property (rec_enh && rec_take);
   c_play_enh: cover property (!rec_enh && play_take);
   c_play_stall: cover property (play_out_valid && !play_out_ready);
endmodule

// [tb/aec_chain_tb.sv]
// Self-checking bench of the enhancement chain control
module aec_chain_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata;
   logic rec_in_valid = 1'b0;
   logic play_in_valid = 1'b0;
   logic signed [15:0] rec_in_data = 16'sh0000;
   logic signed [15:0] play_in_data = 16'sh0000;
   logic rec_in_ready, play_in_ready, rec_out_valid, play_out_valid;
   logic rec_out_ready, play_out_ready, stall = 1'b0;
   logic signed [15:0] rec_out_data, play_out_data;
   int fails = 0;
   int cmp_count = 0;
   logic [7:0] cfg_addr [7] = '{8'h1D, 8'h41, 8'h47, 8'h5C, 8'h64, 8'h85, 8'h40};
   logic [15:0] cfg_on [7] = '{16'h0080, 16'h0001, 16'h0001, 16'h0001, 16'h0001,
                               16'h0001, 16'h0001};

   // Clock at 4 ns period
   always #2 core_clk = ~core_clk;

   aec_chain i_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .rec_in_valid(rec_in_valid), .rec_in_ready(rec_in_ready), .rec_in_data(rec_in_data),
      .play_in_valid(play_in_valid), .play_in_ready(play_in_ready),
      .play_in_data(play_in_data), .rec_out_valid(rec_out_valid),
      .rec_out_ready(rec_out_ready), .rec_out_data(rec_out_data),
      .play_out_valid(play_out_valid), .play_out_ready(play_out_ready),
      .play_out_data(play_out_data));
   aec_audio_sink i_sink (.core_clk(core_clk), .rst_b(rst_b), .stall(stall),
      .rec_out_valid(rec_out_valid), .rec_out_ready(rec_out_ready),
      .rec_out_data(rec_out_data), .play_out_valid(play_out_valid),
      .play_out_ready(play_out_ready), .play_out_data(play_out_data));

   task final_report;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task give_up;
      fails++;
      final_report();
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One-cycle register write strobe
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // Read strobe, data checked one cycle later
   task rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   // Offer one sample and hold it until accepted
   task push(input bit p, input logic [15:0] d);
      int n;
      @(posedge core_clk);
      if (p) begin
         play_in_valid <= 1'b1;
         play_in_data <= d;
      end else begin
         rec_in_valid <= 1'b1;
         rec_in_data <= d;
      end
      for (n = 0; n < 40; n++) begin
         @(negedge core_clk);
         if ((p ? play_in_ready : rec_in_ready) === 1'b1) break;
      end
      if (n == 40) give_up();
      @(posedge core_clk);
      play_in_valid <= 1'b0;
      rec_in_valid <= 1'b0;
   endtask
   // Wait for the sink to hold a word and compare it
   task pull(input bit p, input logic [15:0] exp);
      int n;
      for (n = 0; n < 40; n++) begin
         @(negedge core_clk);
         if ((p ? i_sink.play_q.size() : i_sink.rec_q.size()) > 0) break;
      end
      if (n == 40) give_up();
      chk(p ? i_sink.play_q.pop_front() : i_sink.rec_q.pop_front(), exp);
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge core_clk);
      give_up();
   end

   // Main sequence
   initial begin
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      foreach (cfg_addr[i]) rd(cfg_addr[i], 16'h0000);
      wr(8'h1A, 16'h0001);
      wr(8'h42, 16'h0000);
      wr(8'h65, 16'h1000);
      foreach (cfg_addr[i]) begin
         wr(cfg_addr[i], cfg_on[i]);
         rd(cfg_addr[i], cfg_on[i]);
         wr(cfg_addr[i], 16'h0000);
      end
      wr(8'h24, 16'h0000);
      rd(8'h24, 16'h1000);
      wr(8'hF0, 16'hA5A5);
      rd(8'hF0, 16'hA5A5);
      // Placement modes 0 to 3, both paths untouched with stages off
      for (int m = 0; m < 4; m++) begin
         wr(8'h40, 16'(m));
         rd(8'h40, 16'(m));
         push(1'b0, 16'h8000 + 16'(m));
         push(1'b1, 16'h7FF0 + 16'(m));
         pull(1'b0, 16'h8000 + 16'(m));
         pull(1'b1, 16'h7FF0 + 16'(m));
      end
      // Back-to-back samples into the enhanced record path
      push(1'b0, 16'h1111);
      push(1'b0, 16'h2222);
      pull(1'b0, 16'h1111);
      pull(1'b0, 16'h2222);
      // Low/high-pass on with zero coefficient, then off again
      wr(8'h41, 16'h0001);
      push(1'b0, 16'h1234);
      pull(1'b0, 16'h0000);
      wr(8'h41, 16'h0000);
      push(1'b0, 16'h1234);
      pull(1'b0, 16'h1234);
      // Dynamics stage: release step, anti-clip halving, noise gate
      wr(8'h1D, 16'h0080);
      push(1'b0, 16'h1000);
      pull(1'b0, 16'h1001);
      rd(8'h24, 16'h1001);
      wr(8'h1E, 16'h0001);
      push(1'b0, 16'h7800);
      pull(1'b0, 16'h3C00);
      wr(8'h1D, 16'h0180);
      push(1'b0, 16'h0010);
      pull(1'b0, 16'h0000);
      rd(8'h24, 16'h0801);
      wr(8'h1D, 16'h0000);
      // Stalled sink: direct buffer fills to two and refuses a third
      @(posedge core_clk);
      stall <= 1'b1;
      push(1'b1, 16'h0A0A);
      push(1'b1, 16'h0B0B);
      @(posedge core_clk);
      play_in_valid <= 1'b1;
      play_in_data <= 16'sh0C0C;
      @(negedge core_clk);
      chk(16'(play_in_ready), 16'h0000);
      @(posedge core_clk);
      play_in_valid <= 1'b0;
      stall <= 1'b0;
      pull(1'b1, 16'h0A0A);
      pull(1'b1, 16'h0B0B);
      push(1'b1, 16'h0C0C);
      pull(1'b1, 16'h0C0C);
      final_report();
   end
endmodule

bind aec_chain aec_chain_assertions i_chk (.core_clk(core_clk), .rst_b(rst_b),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .rec_in_valid(rec_in_valid), .rec_in_ready(rec_in_ready),
   .rec_in_data(rec_in_data), .play_in_valid(play_in_valid),
   .play_in_ready(play_in_ready), .play_in_data(play_in_data),
   .rec_out_valid(rec_out_valid), .rec_out_ready(rec_out_ready),
   .rec_out_data(rec_out_data), .play_out_valid(play_out_valid),
   .play_out_ready(play_out_ready), .play_out_data(play_out_data));
